/* File: mfflc_top.sv */
/*
  mfflc_top: per-motor flag set selection, overtravel gating, amp fault
  detection and kill scope logic, with an APB register file and an
  interrupt on kill events.
  Assumes flags arrive asynchronously from pins or from a ring receiver,
  and that motion logic elsewhere supplies direction requests and
  fatal following error pulses on pclk.
  Homing, software limit arithmetic and trajectory work live elsewhere;
  this block only sees whether a software limit is set and whether it
  has been passed.
  An amplifier fault line is pulled high at the pin, so a low-true
  input with nothing attached reads as healthy, and a grounded one as
  a fault.
  Flag set addresses outside the channel map select no flags at all.
  Coordinate system numbers come from a small per-motor register.
*/
// Implementation choices: the register offsets and register access over APB.
// Functional notes
// - each motor picks one flag set: limits, home, fault, enable, index
// - flag set address comes from configuration bits 15:0
// - upper bits zero gives normal mode: low-true fault, kill all
// - bit 16 clear: enable output on when enabled, off when killed
// - bit 16 set: enable output freed for direction or general use
// - bit 17 clear: motion allowed only while matching limit is low
// - positive limit blocks negative motion, negative blocks positive
// - bit 17 set: limit inputs ignored as overtravel limits
// - software travel limits active when non-zero, independent of bit 17
// - bit 18 selects ring flags instead of wired flags
// - bit 20 set ignores the amplifier fault input
// - bits 22:21 choose kill scope: all, coordinate system, this motor
// - any fault halts the program of the offending coordinate system
// - bit 23 selects fault polarity: zero low-true, one high-true
// - flag sets from C000 with stride 4 or 8, channels 9-16 expansion
`timescale 1ns/1ps
module mfflc_top
  import mfflc_pkg::*;
#(
  parameter int NUM_MOTORS = 8,
  parameter int NUM_CS = 8,
  parameter bit WIDE_STRIDE = 1'b0
) (
  // clock, reset and apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // wired flags per channel, asynchronous levels
  input wire logic [MFFLC_NUM_CH-1:0] pos_limit_wired_in,
  input wire logic [MFFLC_NUM_CH-1:0] neg_limit_wired_in,
  input wire logic [MFFLC_NUM_CH-1:0] home_wired_in,
  input wire logic [MFFLC_NUM_CH-1:0] amp_fault_wired_in,
  input wire logic [MFFLC_NUM_CH-1:0] index_wired_in,
  // flags delivered by the ring receiver, asynchronous levels
  input wire logic [MFFLC_NUM_CH-1:0] pos_limit_ring_in,
  input wire logic [MFFLC_NUM_CH-1:0] neg_limit_ring_in,
  input wire logic [MFFLC_NUM_CH-1:0] home_ring_in,
  input wire logic [MFFLC_NUM_CH-1:0] amp_fault_ring_in,
  input wire logic [MFFLC_NUM_CH-1:0] index_ring_in,
  // per-motor requests from motion logic on pclk
  input wire logic [NUM_MOTORS-1:0] move_pos_req,
  input wire logic [NUM_MOTORS-1:0] move_neg_req,
  input wire logic [NUM_MOTORS-1:0] sw_pos_limit_hit,
  input wire logic [NUM_MOTORS-1:0] sw_neg_limit_hit,
  input wire logic [NUM_MOTORS-1:0] sw_pos_limit_set,
  input wire logic [NUM_MOTORS-1:0] sw_neg_limit_set,
  input wire logic [NUM_MOTORS-1:0] fatal_following_error,
  input wire logic [NUM_MOTORS-1:0] gp_output,
  // pin drive, gated motion and per-motor flags
  output logic [MFFLC_NUM_CH-1:0] amp_enable_or_direction_out,
  output logic [NUM_MOTORS-1:0] move_pos_allow,
  output logic [NUM_MOTORS-1:0] move_neg_allow,
  output logic [NUM_MOTORS-1:0] motor_home_flag,
  output logic [NUM_MOTORS-1:0] motor_index_flag,
  output logic [NUM_MOTORS-1:0] motor_killed,
  output logic [NUM_CS-1:0] cs_program_halt,
  // level interrupt from unmasked kill events
  output logic irq
);
  localparam int CH_W = $clog2(MFFLC_NUM_CH);
  localparam int CS_W = $clog2(NUM_CS);
  localparam int MI_W = (NUM_MOTORS > 1) ? $clog2(NUM_MOTORS) : 1;
  localparam int FW = 5 * MFFLC_NUM_CH;
  // lane offsets of each flag kind inside the packed flag vector
  localparam int LN_POS = 0;
  localparam int LN_NEG = MFFLC_NUM_CH;
  localparam int LN_HOME = 2 * MFFLC_NUM_CH;
  localparam int LN_FLT = 3 * MFFLC_NUM_CH;
  localparam int LN_IDX = 4 * MFFLC_NUM_CH;
  // fault lanes rest high like their pulled-up pins, so leaving reset
  // does not look like a low-true fault and fire a program halt
  localparam logic [FW-1:0] SYNC_RST = {{MFFLC_NUM_CH{1'b0}}, {MFFLC_NUM_CH{1'b1}},
                                        {(3*MFFLC_NUM_CH){1'b0}}};
  // address step between neighbouring flag sets; motor n leaves reset on channel n
  localparam logic [MFFLC_CFG_W-1:0] MODE_STEP = WIDE_STRIDE ? MFFLC_CFG_W'(MFFLC_STRIDE_B)
                                                             : MFFLC_CFG_W'(MFFLC_STRIDE_A);

  // three-stage synchronisers for wired and ring flags; the third stage
  // only feeds the agreement filter, so a runt pulse never reaches a motor
  logic [FW-1:0] w_s1_r, w_s2_r, w_s3_r, r_s1_r, r_s2_r, r_s3_r;
  logic [FW-1:0] w_flag_r, r_flag_r;
  logic [FW-1:0] w_raw, r_raw;
  assign w_raw = {index_wired_in, amp_fault_wired_in, home_wired_in,
                  neg_limit_wired_in, pos_limit_wired_in};
  assign r_raw = {index_ring_in, amp_fault_ring_in, home_ring_in,
                  neg_limit_ring_in, pos_limit_ring_in};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_s1_r <= SYNC_RST;
      w_s2_r <= SYNC_RST;
      w_s3_r <= SYNC_RST;
      r_s1_r <= SYNC_RST;
      r_s2_r <= SYNC_RST;
      r_s3_r <= SYNC_RST;
    end else begin
      w_s1_r <= w_raw;
      w_s2_r <= w_s1_r;
      w_s3_r <= w_s2_r;
      r_s1_r <= r_raw;
      r_s2_r <= r_s1_r;
      r_s3_r <= r_s2_r;
    end
  end

  // accept a change only when stages two and three agree; costs one more
  // cycle of latency in exchange for glitch immunity on long limit cables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_flag_r <= SYNC_RST;
      r_flag_r <= SYNC_RST;
    end else begin
      for (int i = 0; i < FW; i++) begin
        if (w_s2_r[i] == w_s3_r[i]) w_flag_r[i] <= w_s3_r[i];
        if (r_s2_r[i] == r_s3_r[i]) r_flag_r[i] <= r_s3_r[i];
      end
    end
  end

  // decode a flag set address into a channel number; used per motor for
  // the flag selection and again for the pin ownership map
  // addresses between two strides round down to the lower channel
  function automatic logic [CH_W:0] addr_to_ch(input logic [15:0] a);
    logic [15:0] off;
    logic [15:0] idx;
    off = a - MFFLC_FLAG_BASE;
    idx = WIDE_STRIDE ? (off >> 3) : (off >> 2);
    // out-of-map address yields channel number MFFLC_NUM_CH (no flags)
    if (a < MFFLC_FLAG_BASE || idx >= 16'(MFFLC_NUM_CH))
      addr_to_ch = (CH_W+1)'(MFFLC_NUM_CH);
    else
      addr_to_ch = idx[CH_W:0];
  endfunction : addr_to_ch

  // registers: configuration word and coordinate system per motor
  logic [MFFLC_CFG_W-1:0] mode_r [NUM_MOTORS];
  logic [CS_W-1:0] csmap_r [NUM_MOTORS];
  // software enable per motor; kills clear it
  logic [NUM_MOTORS-1:0] enable_r;
  // sticky kill events and their interrupt mask
  logic [31:0] mask_r, status_r;
  // combinational kill decision and the halt request it raises
  logic [NUM_MOTORS-1:0] kill_now, fault_evt;
  logic [NUM_CS-1:0] cs_halt_nxt;

  // apb decode; zero wait states, so every access phase is the taking edge
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  // per-motor windows: one word each for configuration and coordinate system
  wire mode_hit = paddr < 12'(4 * NUM_MOTORS);
  wire [11:0] widx = paddr >> 2;
  wire csmap_hit = paddr >= MFFLC_OFF_CSMAP &&
                   paddr < MFFLC_OFF_CSMAP + 12'(4 * NUM_MOTORS);
  wire [11:0] cidx = (paddr - MFFLC_OFF_CSMAP) >> 2;

  // configuration and coordinate system map writes; every motor leaves
  // reset in normal mode on its own flag channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int m = 0; m < NUM_MOTORS; m++) begin
        mode_r[m] <= MFFLC_MODE_RST + MFFLC_CFG_W'(m) * MODE_STEP;
        csmap_r[m] <= '0;
      end
    end else if (wr && mode_hit) begin
      mode_r[widx[MI_W-1:0]] <= pwdata[MFFLC_CFG_W-1:0];
    end else if (wr && csmap_hit) begin
      csmap_r[cidx[MI_W-1:0]] <= pwdata[CS_W-1:0];
    end
  end

  // interrupt mask, same layout as the status word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mask_r <= MFFLC_MASK_RST;
    else if (wr && paddr == MFFLC_OFF_MASK) mask_r <= pwdata;
  end

  // per-motor flag selection and fault detect; every motor has its own
  // selector, so two motors may share one flag set on a paired axis
  logic [NUM_MOTORS-1:0] sel_pos, sel_neg, sel_flt;
  logic [MFFLC_NUM_CH-1:0] en_drive, en_claim;
  genvar g;
  generate
    for (g = 0; g < NUM_MOTORS; g++) begin : g_motor
      wire [CH_W:0] ch = addr_to_ch(mode_r[g][MFFLC_ADDR_W-1:MFFLC_ADDR_LSB]);
      wire valid = ch < (CH_W+1)'(MFFLC_NUM_CH);
      wire [CH_W-1:0] c = ch[CH_W-1:0];
      // bit 18 swaps the whole flag set, never single flags
      wire ring = mode_r[g][MFFLC_BIT_RING];
      wire [FW-1:0] fs = ring ? r_flag_r : w_flag_r;
      // an out-of-map address reads every flag low and raises no fault
      wire plim = valid && fs[LN_POS + c];
      wire nlim = valid && fs[LN_NEG + c];
      wire flt_raw = valid && fs[LN_FLT + c];
      // polarity: low-true when bit clear, which is the default normal mode
      wire flt_act = mode_r[g][MFFLC_BIT_FPOL] ? flt_raw : !flt_raw;
      // bit 17 drops hardware limits only
      wire lim_on = !mode_r[g][MFFLC_BIT_NOLIM];
      assign sel_pos[g] = lim_on && plim;
      assign sel_neg[g] = lim_on && nlim;
      assign sel_flt[g] = valid && !mode_r[g][MFFLC_BIT_NOFLT] && flt_act;
      // software limits stand apart from bit 17
      wire sw_p = sw_pos_limit_set[g] && sw_pos_limit_hit[g];
      wire sw_n = sw_neg_limit_set[g] && sw_neg_limit_hit[g];
      // positive limit blocks negative motion and vice versa
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          move_pos_allow[g] <= 1'b0;
          move_neg_allow[g] <= 1'b0;
          motor_home_flag[g] <= 1'b0;
          motor_index_flag[g] <= 1'b0;
        end else begin
          // a killed motor is refused motion whatever its limits say
          move_pos_allow[g] <= move_pos_req[g] && !sel_neg[g] && !sw_p &&
                               enable_r[g];
          move_neg_allow[g] <= move_neg_req[g] && !sel_pos[g] && !sw_n &&
                               enable_r[g];
          motor_home_flag[g] <= valid && fs[LN_HOME + c];
          motor_index_flag[g] <= valid && fs[LN_IDX + c];
        end
      end
    end
  endgenerate

  // fault events and kill scope resolution; a fault that persists keeps
  // asserting kill_now, so a re-enable cannot stick until it clears;
  // the offender's scope bits pick the victims, not those of the victims
  always_comb begin
    kill_now = '0;
    cs_halt_nxt = '0;
    fault_evt = sel_flt | fatal_following_error;
    for (int m = 0; m < NUM_MOTORS; m++) begin
      if (fault_evt[m]) begin
        cs_halt_nxt[csmap_r[m]] = 1'b1;
        if (mode_r[m][MFFLC_BIT_SCOPE1]) begin
          kill_now[m] = 1'b1;
        end else if (mode_r[m][MFFLC_BIT_SCOPE0]) begin
          for (int k = 0; k < NUM_MOTORS; k++)
            if (csmap_r[k] == csmap_r[m]) kill_now[k] = 1'b1;
        end else begin
          kill_now = '1;
        end
      end
    end
  end

  // enable state: kill wins over a same-cycle software enable
  // writing zero to a bit disables that motor without a kill event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) enable_r <= '0;
    else if (wr && paddr == MFFLC_OFF_ENABLE) enable_r <= pwdata[NUM_MOTORS-1:0] & ~kill_now;
    else enable_r <= enable_r & ~kill_now;
  end

  // registered copies; the halt trails the kill decision by one cycle, motor_killed by two via enable_r
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_program_halt <= '0;
      motor_killed <= '0;
    end else begin
      cs_program_halt <= cs_halt_nxt;
      motor_killed <= ~enable_r;
    end
  end

  // output pin drive: enable per owning motor, otherwise general output
  // ring-mode motors leave the local pin at zero; the remote node owns it
  // when two motors claim one pin the higher motor number wins
  always_comb begin
    en_drive = '0;
    en_claim = '0;
    for (int m = 0; m < NUM_MOTORS; m++) begin
      logic [CH_W:0] ch;
      ch = addr_to_ch(mode_r[m][MFFLC_ADDR_W-1:0]);
      if (ch < (CH_W+1)'(MFFLC_NUM_CH) && !mode_r[m][MFFLC_BIT_RING]) begin
        en_claim[ch[CH_W-1:0]] = 1'b1;
        en_drive[ch[CH_W-1:0]] = mode_r[m][MFFLC_BIT_DIR] ? gp_output[m]
                                                          : enable_r[m];
      end
    end
  end

  // registered so the pin never glitches while mode words are rewritten
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) amp_enable_or_direction_out <= '0;
    else amp_enable_or_direction_out <= en_drive & en_claim;
  end

  // sticky status: kill events set, reading clears; set beats clear
  // a read that meets a new event in the same cycle keeps the event
  wire stat_rd = rd && paddr == MFFLC_OFF_STATUS;
  logic [31:0] evt32;
  assign evt32 = {{(32-NUM_MOTORS){1'b0}}, kill_now & enable_r};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) status_r <= '0;
    else status_r <= (stat_rd ? 32'h0 : status_r) | evt32;
  end
  // level interrupt; it falls once software reads the status word
  assign irq = |(status_r & mask_r);

  // apb read mux; single-cycle access, unmapped reads zero with error
  logic [31:0] rdata;
  logic hit;
  always_comb begin
    rdata = 32'h0;
    hit = 1'b1;
    if (mode_hit) rdata = {8'h00, mode_r[widx[MI_W-1:0]]};
    else if (csmap_hit) rdata = {{(32-CS_W){1'b0}}, csmap_r[cidx[MI_W-1:0]]};
    else if (paddr == MFFLC_OFF_STATUS) rdata = status_r;
    else if (paddr == MFFLC_OFF_MASK) rdata = mask_r;
    else if (paddr == MFFLC_OFF_ENABLE) rdata = {{(32-NUM_MOTORS){1'b0}}, enable_r};
    else if (paddr == MFFLC_OFF_STATE) rdata = {16'h0, sel_flt, ~enable_r};
    else hit = 1'b0;
  end
  // prdata idles at zero so a bus monitor never sees stale register contents
  assign prdata = rd ? rdata : 32'h0;
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
endmodule : mfflc_top

/* File: mfflc_pkg.sv */
/*
  mfflc_pkg: register map, field positions, reset values and flag-set
  address constants for the motor flag select / fault / limit block.
  Assumes a 32-bit APB bus with word-aligned registers.
*/
package mfflc_pkg;
  // register byte offsets
  localparam logic [11:0] MFFLC_OFF_MODE_BASE = 12'h000; // one word per motor
  localparam logic [11:0] MFFLC_OFF_STATUS = 12'h040;
  localparam logic [11:0] MFFLC_OFF_MASK = 12'h044;
  localparam logic [11:0] MFFLC_OFF_ENABLE = 12'h048;
  localparam logic [11:0] MFFLC_OFF_STATE = 12'h04C;
  localparam logic [11:0] MFFLC_OFF_CSMAP = 12'h050;
  // configuration word fields
  localparam int MFFLC_ADDR_LSB = 0;
  localparam int MFFLC_ADDR_W = 16;
  localparam int MFFLC_BIT_DIR = 16;
  localparam int MFFLC_BIT_NOLIM = 17;
  localparam int MFFLC_BIT_RING = 18;
  localparam int MFFLC_BIT_NOFLT = 20;
  localparam int MFFLC_BIT_SCOPE0 = 21;
  localparam int MFFLC_BIT_SCOPE1 = 22;
  localparam int MFFLC_BIT_FPOL = 23;
  localparam int MFFLC_CFG_W = 24;
  // flag-set address map
  localparam logic [15:0] MFFLC_FLAG_BASE = 16'hC000;
  localparam logic [15:0] MFFLC_STRIDE_A = 16'h0004;
  localparam logic [15:0] MFFLC_STRIDE_B = 16'h0008;
  localparam int MFFLC_NUM_CH = 16;
  // reset values
  localparam logic [23:0] MFFLC_MODE_RST = 24'h00C000;
  localparam logic [31:0] MFFLC_MASK_RST = 32'h00000000;
endpackage : mfflc_pkg

/* File: mfflc_properties.sv */
/* mfflc_properties: port-level assertions for mfflc_top.
   Bound from the bench top; one pclk domain, presetn async low. */
`timescale 1ns/1ps
module mfflc_properties #(
  parameter int NUM_MOTORS = 8,
  parameter int NUM_CS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_MOTORS-1:0] move_pos_req,
  input wire logic [NUM_MOTORS-1:0] move_neg_req,
  input wire logic [NUM_MOTORS-1:0] fatal_following_error,
  input wire logic [NUM_MOTORS-1:0] move_pos_allow,
  input wire logic [NUM_MOTORS-1:0] move_neg_allow,
  input wire logic [NUM_MOTORS-1:0] motor_killed,
  input wire logic [NUM_CS-1:0] cs_program_halt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // registered allow never appears without a request behind it
  a_pos_needs_req: assert property ((move_pos_allow & ~$past(move_pos_req)) == '0)
    else $error("positive move allowed without request");
  a_neg_needs_req: assert property ((move_neg_allow & ~$past(move_neg_req)) == '0)
    else $error("negative move allowed without request");
  a_kill_blocks: assert property (((move_pos_allow | move_neg_allow) & motor_killed) == '0)
    else $error("killed motor allowed to move");
  a_ffe_halt: assert property (|fatal_following_error |=> |cs_program_halt)
    else $error("following error did not halt a program");
  a_ffe_kill: assert property (|fatal_following_error |-> ##2
    ((motor_killed & $past(fatal_following_error, 2)) == $past(fatal_following_error, 2)))
    else $error("offending motor not killed");
  a_pready_high: assert property (pready)
    else $error("pready low");
  a_slverr_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  a_prdata_idle: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero outside read access");
endmodule : mfflc_properties

/* File: mfflc_plant.sv */
/* mfflc_plant: amplifiers, limit switches and sensors per channel.
   The bench commands each condition; outputs are plain levels. */
`timescale 1ns/1ps
module mfflc_plant (
  input wire logic [15:0] amp_bad,
  input wire logic [15:0] plim_open,
  input wire logic [15:0] nlim_open,
  input wire logic [15:0] home_seen,
  input wire logic [15:0] ring_home,
  output logic [15:0] pl,
  output logic [15:0] nl,
  output logic [15:0] fl,
  output logic [15:0] hm,
  output logic [15:0] rhm
);
  // fault line pulled high, a failing amp pulls it low
  assign fl = ~amp_bad;
  // open switch lifts the limit line
  assign pl = plim_open;
  assign nl = nlim_open;
  assign hm = home_seen;
  // ring node reports its own home sensor, other flags as wired
  assign rhm = ring_home;
endmodule : mfflc_plant

/* File: motor_flag_fault_limit_control_tb_top.sv */
/* bench top for mfflc_top: APB tasks and directed flag/fault tests.
   Assumes mfflc_pkg, mfflc_plant and mfflc_properties are compiled. */
`timescale 1ns/1ps
module motor_flag_fault_limit_control_tb_top;
  import mfflc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [15:0] bad = '0, plo = '0, nlo = '0, hom = '0, rhom = '0;
  logic [15:0] pl, nl, fl, hm, rhm, aeo;
  logic [7:0] pr = '0, nr = '0, sph = '0, snh = '0, sps = '0, sns = '0, ffe = '0, gp = '0;
  logic [7:0] pa, na, hf, xf, kil, halt;
  logic [7:0] tcfg [7] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h10, 8'h80, 8'h80};
  logic [7:0] tkil [7] = '{8'hFF, 8'h0C, 8'h04, 8'h04, 8'h00, 8'hFF, 8'h00};
  int errors = 0, samples_checked = 0, cyc = 0;
  always #5 pclk = ~pclk;
  mfflc_plant mfflc_plant_i (.amp_bad(bad), .plim_open(plo), .nlim_open(nlo),
    .home_seen(hom), .ring_home(rhom), .pl(pl), .nl(nl), .fl(fl), .hm(hm), .rhm(rhm));
  mfflc_top mfflc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pos_limit_wired_in(pl), .neg_limit_wired_in(nl),
    .home_wired_in(hm), .amp_fault_wired_in(fl), .index_wired_in(hm),
    .pos_limit_ring_in(pl), .neg_limit_ring_in(nl), .home_ring_in(rhm),
    .amp_fault_ring_in(fl), .index_ring_in(rhm), .move_pos_req(pr), .move_neg_req(nr),
    .sw_pos_limit_hit(sph), .sw_neg_limit_hit(snh), .sw_pos_limit_set(sps),
    .sw_neg_limit_set(sns), .fatal_following_error(ffe), .gp_output(gp),
    .amp_enable_or_direction_out(aeo), .move_pos_allow(pa), .move_neg_allow(na),
    .motor_home_flag(hf), .motor_index_flag(xf), .motor_killed(kil),
    .cs_program_halt(halt), .irq(irq));
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one APB transfer; holds everything until pready is sampled high
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : bus
  // flags pass a synchroniser, so give them time to land
  task automatic settle;
    repeat (8) @(posedge pclk);
  endtask : settle
  task automatic test_done;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    bus(0, 12'h000, 0);
    chk("mode_rst", rd, 32'h00C000);
    bus(0, 12'h004, 0);
    chk("mode_rst1", rd, 32'h00C004);
    // each motor on the flag channel of its own feedback encoder
    for (int m = 0; m < 8; m++) begin
      bus(1, 12'(4 * m), 32'hC000 + 4 * m);
      bus(1, 12'(12'h050 + 4 * m), m / 2);
    end
    bus(1, 12'h048, 32'hFF);
    settle;
    chk("enable_out", aeo[7:0], 8'hFF);
    pr <= 8'hFF;
    nr <= 8'hFF;
    plo <= 16'h0001;
    nlo <= 16'h0002;
    settle;
    chk("pos_allow", pa, 8'hFD);
    chk("neg_allow", na, 8'hFE);
    bus(1, 12'h000, 32'h02C000);
    sps <= 8'h01;
    snh <= 8'h02;
    sph <= 8'h01;
    settle;
    chk("neg_nolim", na, 8'hFF);
    chk("pos_swlim", pa, 8'hFC);
    {pr, nr, sps, sph, snh, plo, nlo} <= '0;
    hom <= 16'h0002;
    bus(1, 12'h000, 32'h00C004);
    settle;
    chk("home", hf, 8'h03);
    chk("index", xf, 8'h03);
    bus(1, 12'h000, 32'h04C004);
    settle;
    chk("home_ring", hf, 8'h02);
    bus(1, 12'h000, 32'h01C000);
    settle;
    chk("dir_out", aeo[7:0], 8'hFE);
    gp <= 8'h01;
    settle;
    chk("gp_out", aeo[7:0], 8'hFF);
    gp <= 8'h00;
    bus(1, 12'h000, 32'h00C000);
    // fault scope, ignore and polarity table on motor 2
    for (int i = 0; i < 7; i++) begin
      bus(1, 12'h008, {8'h00, tcfg[i], 16'hC008});
      bad[2] <= (i != 5);
      settle;
      bus(1, 12'h048, 32'hFF);
      settle;
      chk("killed", kil, tkil[i]);
      chk("halt", halt, (tkil[i] != 0) ? 8'h02 : 8'h00);
    end
    bad <= '0;
    settle;
    bus(1, 12'h008, 32'h00C008);
    bus(0, 12'h040, 0);
    bus(1, 12'h048, 32'hFF);
    settle;
    ffe <= 8'h20;
    @(posedge pclk);
    ffe <= 8'h00;
    settle;
    chk("kill_ffe", kil, 8'hFF);
    chk("irq_masked", irq, 1'b0);
    bus(1, 12'h044, 32'hFF);
    chk("irq", irq, 1'b1);
    bus(0, 12'h040, 0);
    chk("status", rd, 32'hFF);
    chk("irq_clr", irq, 1'b0);
    bus(0, 12'h0F0, 0);
    chk("slverr", err, 1'b1);
    bus(1, 12'h048, 32'hFF);
    settle;
    chk("reenable", kil, 8'h00);
    test_done();
  end
endmodule : motor_flag_fault_limit_control_tb_top
bind mfflc_top mfflc_properties #(.NUM_MOTORS(NUM_MOTORS), .NUM_CS(NUM_CS)) mfflc_properties_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .move_pos_req(move_pos_req),
  .move_neg_req(move_neg_req), .fatal_following_error(fatal_following_error),
  .move_pos_allow(move_pos_allow), .move_neg_allow(move_neg_allow),
  .motor_killed(motor_killed), .cs_program_halt(cs_program_halt));
